// *** rtl/hbp_pkg.sv ***
// package of constants and carrier types for the half-bridge pwm controller
package hbp_pkg;
    // -----------------------------------------------------------------
    // timing
    // -----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int BLANK_NS = 200;
    localparam int BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEAD_W = 8;
    localparam int OCDLY_W = 16;
    localparam logic [DEAD_W-1:0] DEAD_MIN = 8'h01;

    // -----------------------------------------------------------------
    // types
    // -----------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_HIGH = 5'h02,
        ST_DEAD1 = 5'h04,
        ST_LOW = 5'h08,
        ST_DEAD2 = 5'h10
    } hbp_state_e;

    // comparator flags, already digitised
    typedef struct packed {
        logic lineLow;
        logic disableHigh;
        logic pwmTrip;
        logic ocTrip;
        logic hiccupTrip;
        logic fbBelowLow;
        logic fbAboveHigh;
    } hbp_flags_s;

    typedef struct packed {
        logic highGate;
        logic lowGate;
    } hbp_gates_s;
endpackage

// *** rtl/hbp_sync.sv ***
// two-flop synchroniser bank for comparator flags
`timescale 1ns/1ns
`default_nettype none
module hbp_sync
    import hbp_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // flags
    input wire hbp_flags_s flagsIn,
    output hbp_flags_s flagsOut
);
    localparam int W = $bits(hbp_flags_s);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // -----------------------------------------------------------------
    // per-bit double flop
    // -----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    meta_q[i] <= 1'b0;
                    sync_q[i] <= 1'b0;
                end else begin
                    meta_q[i] <= flagsIn[i];
                    sync_q[i] <= meta_q[i];
                end
            end
        end
    endgenerate

    assign flagsOut = hbp_flags_s'(sync_q);
endmodule
`default_nettype wire

// *** rtl/hbp_half_bridge_pwm.sv ***
// complementary half-bridge pwm control logic with protections
//
// Function
// [RL1] high side on for D, low side for 1-D, D below half; code ends low at the osc edge with toggle_q set, then idles with gates off.
// [RL2] both gates off for deadtime before the opposite gate turns on.
// [RL3] toggle flop from oscillator picks the switch; switching is half oscillator rate.
// [RL4] light load gives bursts of cycles separated by idle with gates off.
// [RL5] output lets the pfc pre-regulator switch off during burst idle.
// [RL6] line undervoltage shutdown is not latched; resumes automatically.
// [RL7] first-level overcurrent delays shutdown; input selects latched or auto-restart.
// [RL8] second-level overcurrent latches the device off.
// [RL9] current-sense comparators ignored for blanking interval after high-side turn-on.
// [RL10] line low stops switching, low power, discharges soft-start.
// [RL11] line hysteresis current enable equals line-low comparator flag.
// [RL12] disable above threshold sets latch, stops gates, low consumption.
// [RL13] disable latch clears only on supply undervoltage lockout.
// [RL14] oscillator sets high gate; current trip clears it; low follows after deadtime.
// [RL15] blanking lasts a fixed 200 ns.
// [RL16] pulse-by-pulse trip ends high pulse; hiccup level shuts device down.
// [RL17] feedback below low threshold stops; above high threshold restarts.
// [RL18] deadtime is a configured cycle count; gates never both active.
// [RL19] any shutdown or idle holds gates off and resets toggle to high side.
`timescale 1ns/1ns
`default_nettype none
module hbp_half_bridge_pwm
    import hbp_pkg::*;
#(
    parameter logic [OCDLY_W-1:0] OC_DELAY = 16'h1000
)(
    // clock and reset (reset_n low = supply undervoltage lockout)
    input wire logic clk,
    input wire logic reset_n,
    // oscillator and comparator inputs (asynchronous)
    input wire logic oscillatorTimingInput,
    input wire hbp_flags_s flagsRaw,
    // configuration
    input wire logic [DEAD_W-1:0] deadCycles,
    input wire logic ocLatchMode,
    // gate commands
    output hbp_gates_s gates,
    // status to the analog side
    output logic lineHystEn,
    output logic pfcOffReq,
    output logic softStartDischarge,
    output logic lowPowerMode,
    output logic faultLatched
);
    hbp_flags_s f;
    hbp_sync u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .flagsIn(flagsRaw),
        .flagsOut(f)
    );

    // -----------------------------------------------------------------
    // oscillator synchroniser and edge detect
    // -----------------------------------------------------------------
    logic oscMeta_q, oscSync_q, oscPrev_q;
    logic oscEdge;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            oscMeta_q <= 1'b0;
            oscSync_q <= 1'b0;
            oscPrev_q <= 1'b0;
        end else begin
            oscMeta_q <= oscillatorTimingInput;
            oscSync_q <= oscMeta_q;
            oscPrev_q <= oscSync_q;
        end
    end
    assign oscEdge = oscSync_q & ~oscPrev_q;

    // -----------------------------------------------------------------
    // protection latches
    // -----------------------------------------------------------------
    logic disLatch_q, hiccupLatch_q, satLatch_q, burstIdle_q, ocShut_q;
    logic [OCDLY_W-1:0] ocCnt_q;
    logic blanked;
    logic stop;

    // disable latch, cleared only by reset (lockout)
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) disLatch_q <= 1'b0; // see [RL13]
        else if (f.disableHigh) disLatch_q <= 1'b1; // see [RL12]
    end

    // second level: saturation latch-off; hiccup stands in the same latch set
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            satLatch_q <= 1'b0;
            hiccupLatch_q <= 1'b0;
        end else if (!blanked && f.hiccupTrip) begin
            satLatch_q <= 1'b1; // see [RL8]
            hiccupLatch_q <= 1'b1; // see [RL16]
        end
    end

    // first level: delayed shutdown, latched or auto-restart
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ocCnt_q <= '0;
            ocShut_q <= 1'b0;
        end else if (ocShut_q) begin
            if (!ocLatchMode && f.lineLow) ocShut_q <= 1'b0; // see [RL7]
            if (!ocLatchMode && !f.ocTrip) ocShut_q <= 1'b0; // auto-restart
            ocCnt_q <= '0;
        end else if (!blanked && f.ocTrip) begin
            if (ocCnt_q == OC_DELAY) ocShut_q <= 1'b1; // see [RL7]
            else ocCnt_q <= ocCnt_q + 1'b1;
        end else if (!f.ocTrip && ocCnt_q != '0 && oscEdge) begin
            ocCnt_q <= ocCnt_q - 1'b1; // slow discharge between trips
        end
    end

    // burst hysteresis on feedback
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) burstIdle_q <= 1'b0;
        else if (f.fbBelowLow) burstIdle_q <= 1'b1; // see [RL17] [RL4]
        else if (f.fbAboveHigh) burstIdle_q <= 1'b0; // see [RL17]
    end

    // line low is not latched, it gates directly
    assign stop = f.lineLow | disLatch_q | satLatch_q | ocShut_q | burstIdle_q; // see [RL6]

    // -----------------------------------------------------------------
    // switching state machine
    // -----------------------------------------------------------------
    hbp_state_e state_q;
    logic toggle_q; // 0: next oscillator edge starts high side
    logic [DEAD_W-1:0] deadCnt_q;
    logic [7:0] blankCnt_q;
    logic [DEAD_W-1:0] deadLoad;
    assign deadLoad = (deadCycles < DEAD_MIN) ? DEAD_MIN : deadCycles; // see [RL18]
    // blanking only masks the high-side pulse; outside it no switch current flows
    assign blanked = (state_q == ST_HIGH) && (blankCnt_q != 8'h00); // see [RL9]

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            toggle_q <= 1'b0;
            deadCnt_q <= '0;
        end else if (stop) begin
            state_q <= ST_IDLE; // see [RL19]
            toggle_q <= 1'b0; // see [RL19]
            deadCnt_q <= '0;
        end else begin
            if (oscEdge) toggle_q <= ~toggle_q; // see [RL3]
            case (state_q)
                ST_IDLE: begin
                    if (oscEdge && !toggle_q) state_q <= ST_HIGH; // see [RL14]
                end
                ST_HIGH: begin
                    // trip or phase end of high half closes the pulse
                    if ((!blanked && (f.pwmTrip || f.ocTrip)) || oscEdge) begin // see [RL16] [RL1]
                        state_q <= ST_DEAD1; // see [RL14]
                        deadCnt_q <= deadLoad;
                    end
                end
                ST_DEAD1: begin
                    if (deadCnt_q <= 8'h01) state_q <= ST_LOW; // see [RL2]
                    else deadCnt_q <= deadCnt_q - 1'b1;
                end
                ST_LOW: begin
                    if (oscEdge && toggle_q) begin // see [RL1]
                        state_q <= ST_DEAD2;
                        deadCnt_q <= deadLoad;
                    end
                end
                ST_DEAD2: begin
                    if (deadCnt_q <= 8'h01) state_q <= ST_IDLE; // see [RL2]
                    else deadCnt_q <= deadCnt_q - 1'b1;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // leading-edge blanking after each high-side turn-on
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) blankCnt_q <= 8'h00;
        else if (state_q != ST_HIGH) blankCnt_q <= 8'(BLANK_CYC); // see [RL15] [RL9]
        else if (blankCnt_q != 8'h00) blankCnt_q <= blankCnt_q - 8'h01; // see [RL9]
    end

    // -----------------------------------------------------------------
    // registered outputs
    // -----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            gates <= '0;
            lineHystEn <= 1'b0;
            pfcOffReq <= 1'b0;
            softStartDischarge <= 1'b1;
            lowPowerMode <= 1'b1;
            faultLatched <= 1'b0;
        end else begin
            gates.highGate <= !stop && (state_q == ST_HIGH); // see [RL18]
            gates.lowGate <= !stop && (state_q == ST_LOW); // see [RL18]
            lineHystEn <= f.lineLow; // see [RL11]
            pfcOffReq <= burstIdle_q; // see [RL5]
            softStartDischarge <= f.lineLow; // see [RL10]
            lowPowerMode <= f.lineLow | disLatch_q | hiccupLatch_q; // see [RL10] [RL12]
            faultLatched <= disLatch_q | satLatch_q | (ocShut_q & ocLatchMode);
        end
    end

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    property p_noOverlap;
        @(posedge clk) disable iff (!reset_n) !(gates.highGate && gates.lowGate);
    endproperty
    a_noOverlap: assert property (p_noOverlap) else $error("both gates on"); // see [RL18]

    property p_deadAfterHigh;
        @(posedge clk) disable iff (!reset_n)
            $fell(gates.highGate) |-> !gates.lowGate;
    endproperty
    a_deadAfterHigh: assert property (p_deadAfterHigh) else $error("no deadtime"); // see [RL2]

    property p_stopGates;
        @(posedge clk) disable iff (!reset_n) stop |=> !gates.highGate && !gates.lowGate;
    endproperty
    a_stopGates: assert property (p_stopGates) else $error("gate on while stopped"); // see [RL19]

    property p_hyst;
        @(posedge clk) disable iff (!reset_n) ##1 lineHystEn == $past(f.lineLow);
    endproperty
    a_hyst: assert property (p_hyst) else $error("hysteresis enable wrong"); // see [RL11]

    property p_disHold;
        @(posedge clk) disable iff (!reset_n) disLatch_q |=> disLatch_q;
    endproperty
    a_disHold: assert property (p_disHold) else $error("disable latch released"); // see [RL13]

    property p_disSet;
        @(posedge clk) disable iff (!reset_n) f.disableHigh |=> disLatch_q;
    endproperty
    a_disSet: assert property (p_disSet) else $error("disable not latched"); // see [RL12]

    property p_satHold;
        @(posedge clk) disable iff (!reset_n) satLatch_q |=> satLatch_q ##1 !gates.highGate;
    endproperty
    a_satHold: assert property (p_satHold) else $error("saturation latch lost"); // see [RL8]

    // a trip seen inside the blanking window must not close the pulse
    property p_blank;
        @(posedge clk) disable iff (!reset_n)
            (state_q == ST_HIGH) && blanked && !stop && !oscEdge |=> state_q == ST_HIGH;
    endproperty
    a_blank: assert property (p_blank) else $error("pulse ended in blanking"); // see [RL9]

    property p_pfc;
        @(posedge clk) disable iff (!reset_n) burstIdle_q |=> pfcOffReq;
    endproperty
    a_pfc: assert property (p_pfc) else $error("pfc not told off"); // see [RL5]

    c_high: cover property (@(posedge clk) disable iff (!reset_n) $rose(gates.highGate));
    c_low: cover property (@(posedge clk) disable iff (!reset_n) $rose(gates.lowGate));
    c_burst: cover property (@(posedge clk) disable iff (!reset_n) $fell(burstIdle_q));
    c_ocShut: cover property (@(posedge clk) disable iff (!reset_n) $rose(ocShut_q));
endmodule
`default_nettype wire

// *** tb/hbp_bridge_model.sv ***
// partner model: oscillator source and current-sense ramp behind the half bridge
`timescale 1ns/1ns
`default_nettype none
module hbp_bridge_model
    import hbp_pkg::*;
#(
    parameter int OSC_HALF = 40,
    parameter int RAMP_CYC = 20
)(
    // clock
    input wire logic clk,
    // bench control
    input wire logic oscRun,
    input wire logic tripHold,
    // gate commands from the controller
    input wire hbp_gates_s gates,
    // oscillator level and current-sense trip
    output logic oscOut,
    output logic pwmTripOut
);
    int oscCnt = 0;
    int rampCnt = 0;

    initial begin
        oscOut = 1'b0;
        pwmTripOut = 1'b0;
    end

    // oscillator stands low while stopped, so no stray edge reaches the controller
    always @(negedge clk) begin
        if (!oscRun) begin
            oscOut <= 1'b0;
            oscCnt <= 0;
        end else if (oscCnt == OSC_HALF - 1) begin
            oscOut <= ~oscOut;
            oscCnt <= 0;
        end else begin
            oscCnt <= oscCnt + 1;
        end
    end

    // switch current ramps while the high side conducts and resets when it stops
    always @(negedge clk) begin
        rampCnt <= gates.highGate ? rampCnt + 1 : 0;
        pwmTripOut <= tripHold || (gates.highGate && rampCnt >= RAMP_CYC);
    end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking testbench for the half-bridge pwm controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e, m) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
    $display("mismatch at %0t: %s", $time, m); end end
module tb_top
    import hbp_pkg::*;
;
    localparam int OSC_HALF = 40;
    localparam int RAMP_CYC = 20;
    localparam logic [OCDLY_W-1:0] OC_DLY = 16'h0010;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic oscRun = 1'b0;
    logic tripHold = 1'b0;
    logic ocLatchMode = 1'b0;
    logic [DEAD_W-1:0] deadCycles = 8'h05;
    logic osc;
    logic pTrip;
    hbp_flags_s fl = '0;
    hbp_flags_s flagsIn;
    hbp_gates_s gates;
    logic lineHystEn, pfcOffReq, softStartDischarge, lowPowerMode, faultLatched;
    int err_total = 0;
    int cmp_count = 0;
    int oscRises, highRises, overlap, gap, lastOn, firstOn, minDead, minHigh, maxHigh, hiLen;
    bit oscPrev, hiPrev, loPrev, hiValid;

    // current-sense trip comes from the partner, all other flags from the bench
    assign flagsIn = hbp_flags_s'({fl.lineLow, fl.disableHigh, pTrip, fl.ocTrip,
        fl.hiccupTrip, fl.fbBelowLow, fl.fbAboveHigh});

    hbp_half_bridge_pwm #(.OC_DELAY(OC_DLY)) i_dut (.clk(clk), .reset_n(reset_n),
        .oscillatorTimingInput(osc), .flagsRaw(flagsIn), .deadCycles(deadCycles),
        .ocLatchMode(ocLatchMode), .gates(gates), .lineHystEn(lineHystEn),
        .pfcOffReq(pfcOffReq), .softStartDischarge(softStartDischarge),
        .lowPowerMode(lowPowerMode), .faultLatched(faultLatched));

    hbp_bridge_model #(.OSC_HALF(OSC_HALF), .RAMP_CYC(RAMP_CYC)) i_model (.clk(clk),
        .oscRun(oscRun), .tripHold(tripHold), .gates(gates), .oscOut(osc), .pwmTripOut(pTrip));

    always #10 clk = ~clk;

    // gate monitor: overlap, dead gaps, high pulse widths, edge counts
    always @(negedge clk) begin
        if (osc && !oscPrev) oscRises++;
        if (gates.highGate && gates.lowGate) overlap++;
        if ((gates.highGate && !hiPrev) || (gates.lowGate && !loPrev)) begin
            if (lastOn != 0 && lastOn != (gates.highGate ? 1 : 2) && gap < minDead) minDead = gap;
            lastOn = gates.highGate ? 1 : 2;
            if (firstOn == 0) firstOn = lastOn;
        end
        if (gates.highGate && !hiPrev) begin
            highRises++;
            hiLen = 0;
            hiValid = 1;
        end
        if (!gates.highGate && hiPrev && hiValid) begin
            if (hiLen < minHigh) minHigh = hiLen;
            if (hiLen > maxHigh) maxHigh = hiLen;
        end
        hiLen++;
        gap = (gates.highGate || gates.lowGate) ? 0 : gap + 1;
        oscPrev = osc;
        hiPrev = gates.highGate;
        loPrev = gates.lowGate;
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // wait n falling edges, optionally clearing the monitor first
    task automatic run(input int n, input bit clr);
        if (clr) begin
            oscRises = 0;
            highRises = 0;
            overlap = 0;
            lastOn = 0;
            firstOn = 0;
            minDead = 999;
            minHigh = 999;
            maxHigh = 0;
            hiValid = 0;
        end
        repeat (n) @(negedge clk);
    endtask

    task automatic do_reset();
        reset_n = 1'b0;
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
    endtask

    task automatic t_switch(input logic [DEAD_W-1:0] dc, input int expDead);
        int rateErr;
        deadCycles = dc;
        run(20, 1'b1);
        run(800, 1'b0);
        rateErr = highRises * 2 - oscRises;
        `CHK(overlap, 0, "gates overlap")
        `CHK(minDead >= expDead && minDead < 999, 1'b1, "deadtime short")
        `CHK(maxHigh < 2 * OSC_HALF, 1'b1, "high duty not below half")
        `CHK(maxHigh <= RAMP_CYC + 8, 1'b1, "trip did not end high")
        `CHK(rateErr >= -2 && rateErr <= 2, 1'b1, "rate")
    endtask

    task automatic t_blank();
        tripHold = 1'b1;
        run(20, 1'b1);
        run(600, 1'b0);
        tripHold = 1'b0;
        `CHK(minHigh >= BLANK_CYC && minHigh < 999, 1'b1, "blanking short")
        `CHK(maxHigh <= BLANK_CYC + 6, 1'b1, "trip ignored after blanking")
    endtask

    task automatic t_line();
        fl.lineLow = 1'b1;
        run(10, 1'b1);
        `CHK(lineHystEn, 1'b1, "hysteresis off")
        `CHK(softStartDischarge, 1'b1, "no discharge")
        `CHK(lowPowerMode, 1'b1, "no low power")
        run(300, 1'b1);
        `CHK(highRises, 0, "switching in line low")
        fl.lineLow = 1'b0;
        run(10, 1'b1);
        `CHK(lineHystEn, 1'b0, "hysteresis stuck")
        `CHK(softStartDischarge | lowPowerMode, 1'b0, "line low stuck")
        run(300, 1'b0);
        `CHK(highRises > 0, 1'b1, "no restart")
        `CHK(firstOn, 1, "restart not on high side")
    endtask

    task automatic t_burst();
        fl.fbBelowLow = 1'b1;
        run(10, 1'b1);
        fl.fbBelowLow = 1'b0;
        run(300, 1'b1);
        `CHK(pfcOffReq, 1'b1, "pfc not released")
        `CHK(highRises, 0, "switching in burst idle")
        fl.fbAboveHigh = 1'b1;
        run(10, 1'b1);
        fl.fbAboveHigh = 1'b0;
        run(300, 1'b0);
        `CHK(pfcOffReq, 1'b0, "pfc stuck off")
        `CHK(firstOn, 1, "burst not on high side")
    endtask

    task automatic t_fault(input int kind, input logic mode);
        ocLatchMode = mode;
        if (kind == 0) fl.ocTrip = 1'b1;
        if (kind == 1) fl.hiccupTrip = 1'b1;
        if (kind == 2) fl.disableHigh = 1'b1;
        run(300, 1'b1);
        `CHK(highRises <= 1, 1'b1, "switching during fault")
        fl = '0;
        fl.lineLow = (kind == 2);
        run(20, 1'b0);
        fl.lineLow = 1'b0;
        run(300, 1'b1);
        `CHK(faultLatched, mode, "fault latch")
        `CHK(highRises > 0, !mode, "restart after fault")
        if (kind > 0) `CHK(lowPowerMode, 1'b1, "no low power in fault")
        do_reset();
        run(300, 1'b1);
        `CHK(faultLatched, 1'b0, "latch kept over reset")
    endtask

    initial begin
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        oscRun = 1'b1;
        t_switch(8'h05, 5);
        t_switch(8'h00, 1);
        t_blank();
        t_line();
        t_burst();
        t_fault(0, 1'b0);
        t_fault(0, 1'b1);
        t_fault(1, 1'b1);
        t_fault(2, 1'b1);
        close_out();
    end

    initial begin
        #1000000;
        err_total++;
        close_out();
    end
endmodule
`default_nettype wire
